// *** rtl/port_defs.svh ***
`ifndef PORT_DEFS_SVH
`define PORT_DEFS_SVH

// bus geometry: printed offsets are word indices, byte address is four times the index
`define ADDR_W          18
`define IDX_W           16
`define IDX_PIN_LEVEL   16'hf208
`define IDX_PULL_LOW    16'hf20a
`define IDX_PULL_HIGH   16'hf20b
`define IDX_LATCH       16'hf210
`define IDX_DRIVE_LOW   16'hf212
`define IDX_DRIVE_HIGH  16'hf213
`define IDX_FUNC_LOW    16'hf214
`define IDX_FUNC_HIGH   16'hf215

`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

// reset values
`define IN_CFG_RST      2'h0
`define OUT_CFG_RST     4'h0

// input pull codes {high,low}
`define PULL_HIZ        2'b00
`define PULL_DOWN       2'b01
`define PULL_UP         2'b10

// output drive codes {high,low}
`define DRV_HIZ         2'b00
`define DRV_PCH_OD      2'b01
`define DRV_NCH_OD      2'b10
`define DRV_CMOS        2'b11

// output function codes {high,low}
`define FUNC_GPIO       2'b00
`define FUNC_CLOCK      2'b01
`define FUNC_TIMER      2'b10

// oscillator mode field codes
`define OSC_MODE_XTAL   2'b00
`define OSC_MODE_EXTCLK 2'b01

`endif

// *** rtl/port_pkg.sv ***
package port_pkg;

    typedef struct packed {
        logic [1:0] low;
        logic [1:0] high;
    } in_cfg_t;

    typedef struct packed {
        logic [3:0] latch;
        logic [3:0] drv_low;
        logic [3:0] drv_high;
        logic [3:0] fn_low;
        logic [3:0] fn_high;
    } out_cfg_t;

    typedef struct packed {
        logic [3:0] level;
        logic [3:0] oe;
    } out_pins_t;

    typedef struct packed {
        logic [1:0] up;
        logic [1:0] down;
    } pull_ctl_t;

endpackage

// *** rtl/input_port1_output_port2.sv ***
// Chosen here: register access over AXI4-Lite.
`include "port_defs.svh"

module input_port1_output_port2 (
    input  wire logic                  mclk,
    input  wire logic                  rst_n,
    input  wire logic [`ADDR_W-1:0]    awaddr,
    input  wire logic [2:0]            awprot,
    input  wire logic                  awvalid,
    output logic                       awready,
    input  wire logic [31:0]           wdata,
    input  wire logic [3:0]            wstrb,
    input  wire logic                  wvalid,
    output logic                       wready,
    output logic [1:0]                 bresp,
    output logic                       bvalid,
    input  wire logic                  bready,
    input  wire logic [`ADDR_W-1:0]    araddr,
    input  wire logic [2:0]            arprot,
    input  wire logic                  arvalid,
    output logic                       arready,
    output logic [31:0]                rdata,
    output logic [1:0]                 rresp,
    output logic                       rvalid,
    input  wire logic                  rready,
    input  wire logic                  first_input_pin,
    input  wire logic                  second_input_pin,
    input  wire logic [1:0]            osc_mode,
    input  wire logic                  low_speed_clock_out,
    input  wire logic                  high_speed_clock_out,
    input  wire logic                  timer_nine_output,
    input  wire logic                  timer_b_output,
    output port_pkg::out_pins_t        out_pins,
    output port_pkg::pull_ctl_t        pull_ctl,
    output logic [1:0]                 osc_pin_owned
);

    function automatic logic hit(input logic [`ADDR_W-1:0] addr, input logic [`IDX_W-1:0] idx);
        hit = (addr[`ADDR_W-1:2] == idx);
    endfunction

    function automatic logic [1:0] osc_owned(input logic [1:0] mode);
        if (mode == `OSC_MODE_XTAL) begin
            osc_owned = 2'b11;
        end else if (mode == `OSC_MODE_EXTCLK) begin
            osc_owned = 2'b01;
        end else begin
            osc_owned = 2'b00;
        end
    endfunction

    port_pkg::in_cfg_t      in_cfg;
    port_pkg::in_cfg_t      next_in_cfg;
    port_pkg::out_cfg_t     out_cfg;
    port_pkg::out_cfg_t     next_out_cfg;
    port_pkg::out_pins_t    next_out_pins;
    port_pkg::pull_ctl_t    next_pull_ctl;
    logic [1:0]             next_osc_pin_owned;
    logic [`ADDR_W-1:0]     aw_addr;
    logic [`ADDR_W-1:0]     next_aw_addr;
    logic                   aw_held;
    logic                   next_aw_held;
    logic [31:0]            w_data;
    logic [31:0]            next_w_data;
    logic [3:0]             w_strb;
    logic [3:0]             next_w_strb;
    logic                   w_held;
    logic                   next_w_held;
    logic                   next_awready;
    logic                   next_wready;
    logic [1:0]             next_bresp;
    logic                   next_bvalid;
    logic                   next_arready;
    logic [31:0]            next_rdata;
    logic [1:0]             next_rresp;
    logic                   next_rvalid;
    logic [1:0]             pin_level;
    logic [1:0]             owned_now;
    logic [3:0]             sec_src;

    // a dedicated oscillator pin reads low so software never mistakes the
    // crystal swing for an input level
    always_comb begin
        owned_now = osc_owned(osc_mode);
        pin_level = {~owned_now[1] & second_input_pin,
                     ~owned_now[0] & first_input_pin};
        sec_src   = {timer_b_output, timer_nine_output,
                     high_speed_clock_out, low_speed_clock_out};
    end

    always_comb begin
        logic [1:0] fn;
        logic [1:0] drv;
        logic       src;
        fn  = 2'b00;
        drv = 2'b00;
        src = 1'b0;
        next_in_cfg        = in_cfg;
        next_out_cfg       = out_cfg;
        next_aw_addr       = aw_addr;
        next_aw_held       = aw_held;
        next_w_data        = w_data;
        next_w_strb        = w_strb;
        next_w_held        = w_held;
        next_awready       = awready;
        next_wready        = wready;
        next_bresp         = bresp;
        next_bvalid        = bvalid;
        next_arready       = arready;
        next_rdata         = rdata;
        next_rresp         = rresp;
        next_rvalid        = rvalid;
        next_osc_pin_owned = osc_owned(osc_mode);

        if (awvalid && awready) begin
            next_aw_addr = awaddr;
            next_aw_held = 1'b1;
            next_awready = 1'b0;
        end
        if (wvalid && wready) begin
            next_w_data = wdata;
            next_w_strb = wstrb;
            next_w_held = 1'b1;
            next_wready = 1'b0;
        end

        // only byte lanes 0 and 1 carry data; lane 1 on the pull and drive low
        // registers reaches its high partner, giving the 16-bit word view
        if (aw_held && w_held && !bvalid) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = `RESP_OKAY;
            if (hit(aw_addr, `IDX_PULL_LOW)) begin
                if (w_strb[0]) next_in_cfg.low = w_data[1:0];
                if (w_strb[1]) next_in_cfg.high = w_data[9:8];
            end else if (hit(aw_addr, `IDX_PULL_HIGH)) begin
                if (w_strb[0]) next_in_cfg.high = w_data[1:0];
            end else if (hit(aw_addr, `IDX_LATCH)) begin
                if (w_strb[0]) next_out_cfg.latch = w_data[3:0];
            end else if (hit(aw_addr, `IDX_DRIVE_LOW)) begin
                if (w_strb[0]) next_out_cfg.drv_low = w_data[3:0];
                if (w_strb[1]) next_out_cfg.drv_high = w_data[11:8];
            end else if (hit(aw_addr, `IDX_DRIVE_HIGH)) begin
                if (w_strb[0]) next_out_cfg.drv_high = w_data[3:0];
            end else if (hit(aw_addr, `IDX_FUNC_LOW)) begin
                if (w_strb[0]) next_out_cfg.fn_low = w_data[3:0];
            end else if (hit(aw_addr, `IDX_FUNC_HIGH)) begin
                if (w_strb[0]) next_out_cfg.fn_high = w_data[3:0];
            end else if (hit(aw_addr, `IDX_PIN_LEVEL)) begin
                next_bresp = `RESP_OKAY;
            end else begin
                next_bresp = `RESP_SLVERR;
            end
        end
        if (bvalid && bready) begin
            next_bvalid  = 1'b0;
            next_awready = 1'b1;
            next_wready  = 1'b1;
        end

        if (arvalid && arready) begin
            next_arready = 1'b0;
            next_rvalid  = 1'b1;
            next_rresp   = `RESP_OKAY;
            next_rdata   = 32'h0000_0000;
            if (hit(araddr, `IDX_PIN_LEVEL)) begin
                next_rdata[1:0] = pin_level;
            end else if (hit(araddr, `IDX_PULL_LOW)) begin
                next_rdata[1:0] = in_cfg.low;
                next_rdata[9:8] = in_cfg.high;
            end else if (hit(araddr, `IDX_PULL_HIGH)) begin
                next_rdata[1:0] = in_cfg.high;
            end else if (hit(araddr, `IDX_LATCH)) begin
                next_rdata[3:0] = out_cfg.latch;
            end else if (hit(araddr, `IDX_DRIVE_LOW)) begin
                next_rdata[3:0]  = out_cfg.drv_low;
                next_rdata[11:8] = out_cfg.drv_high;
            end else if (hit(araddr, `IDX_DRIVE_HIGH)) begin
                next_rdata[3:0] = out_cfg.drv_high;
            end else if (hit(araddr, `IDX_FUNC_LOW)) begin
                next_rdata[3:0] = out_cfg.fn_low;
            end else if (hit(araddr, `IDX_FUNC_HIGH)) begin
                next_rdata[3:0] = out_cfg.fn_high;
            end else begin
                next_rresp = `RESP_SLVERR;
            end
        end
        if (rvalid && rready) begin
            next_rvalid  = 1'b0;
            next_arready = 1'b1;
        end

        for (int i = 0; i < 2; i++) begin
            next_pull_ctl.up[i]   = ({in_cfg.high[i], in_cfg.low[i]} == `PULL_UP);
            next_pull_ctl.down[i] = ({in_cfg.high[i], in_cfg.low[i]} == `PULL_DOWN);
        end

        // prohibited function codes fall back to the latch rather than glitch
        for (int i = 0; i < 4; i++) begin
            fn  = {out_cfg.fn_high[i], out_cfg.fn_low[i]};
            drv = {out_cfg.drv_high[i], out_cfg.drv_low[i]};
            src = out_cfg.latch[i];
            if (fn == `FUNC_CLOCK && i < 2) begin
                src = sec_src[i];
            end else if (fn == `FUNC_TIMER && i >= 2) begin
                src = sec_src[i];
            end
            next_out_pins.level[i] = src;
            case (drv)
                `DRV_HIZ:    next_out_pins.oe[i] = 1'b0;
                `DRV_PCH_OD: next_out_pins.oe[i] = src;
                `DRV_NCH_OD: next_out_pins.oe[i] = ~src;
                default:     next_out_pins.oe[i] = 1'b1;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            in_cfg        <= '{low: `IN_CFG_RST, high: `IN_CFG_RST};
            out_cfg       <= '{`OUT_CFG_RST, `OUT_CFG_RST, `OUT_CFG_RST,
                               `OUT_CFG_RST, `OUT_CFG_RST};
            out_pins      <= '{level: 4'h0, oe: 4'h0};
            pull_ctl      <= '{up: 2'h0, down: 2'h0};
            osc_pin_owned <= 2'h0;
            aw_addr       <= '0;
            aw_held       <= 1'b0;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            w_held        <= 1'b0;
            awready       <= 1'b1;
            wready        <= 1'b1;
            bresp         <= `RESP_OKAY;
            bvalid        <= 1'b0;
            arready       <= 1'b1;
            rdata         <= 32'h0000_0000;
            rresp         <= `RESP_OKAY;
            rvalid        <= 1'b0;
        end else begin
            in_cfg        <= next_in_cfg;
            out_cfg       <= next_out_cfg;
            out_pins      <= next_out_pins;
            pull_ctl      <= next_pull_ctl;
            osc_pin_owned <= next_osc_pin_owned;
            aw_addr       <= next_aw_addr;
            aw_held       <= next_aw_held;
            w_data        <= next_w_data;
            w_strb        <= next_w_strb;
            w_held        <= next_w_held;
            awready       <= next_awready;
            wready        <= next_wready;
            bresp         <= next_bresp;
            bvalid        <= next_bvalid;
            arready       <= next_arready;
            rdata         <= next_rdata;
            rresp         <= next_rresp;
            rvalid        <= next_rvalid;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_level_ext_clock: assert property (
        (arvalid && arready && hit(araddr, `IDX_PIN_LEVEL) && osc_mode == `OSC_MODE_EXTCLK)
        |=> (rdata[1:0] == {$past(second_input_pin), 1'b0}))
        else $error("level read wrong in external clock mode");

    a_level_xtal_zero: assert property (
        (arvalid && arready && hit(araddr, `IDX_PIN_LEVEL) && osc_mode == `OSC_MODE_XTAL)
        |=> (rdata[1:0] == 2'b00))
        else $error("oscillator pins read as inputs");

    a_upper_bits_zero: assert property (
        rvalid |-> (rdata[31:12] == 20'h0_0000 && rdata[7:4] == 4'h0))
        else $error("unimplemented read bits not zero");

    a_pull_decode: assert property (
        ##1 (pull_ctl.up == $past(in_cfg.high & ~in_cfg.low)
             && pull_ctl.down == $past(~in_cfg.high & in_cfg.low)))
        else $error("pull enables disagree with config");

    a_reset_clears: assert property (
        $rose(rst_n) |-> (in_cfg == '0 && out_cfg == '0 && out_pins.oe == 4'h0))
        else $error("config not cleared by reset");

    a_word_write_high: assert property (
        (aw_held && w_held && !bvalid && hit(aw_addr, `IDX_PULL_LOW) && w_strb[1])
        |=> (in_cfg.high == $past(w_data[9:8]) && bvalid))
        else $error("word write missed high config");

    a_osc_owned: assert property (
        (osc_mode == `OSC_MODE_XTAL) [*2] |-> (osc_pin_owned == 2'b11))
        else $error("crystal mode does not own both pins");

    a_latch_to_pins: assert property (
        (out_cfg.fn_low == 4'h0 && out_cfg.fn_high == 4'h0
         && out_cfg.drv_low == 4'hf && out_cfg.drv_high == 4'hf)
        |=> (out_pins.level == $past(out_cfg.latch) && out_pins.oe == 4'hf))
        else $error("cmos pins do not follow latch");

    a_latch_readback: assert property (
        (arvalid && arready && hit(araddr, `IDX_LATCH))
        |=> (rvalid && rdata[3:0] == $past(out_cfg.latch)))
        else $error("latch read back wrong");

    a_low_clock_out: assert property (
        ({out_cfg.fn_high[0], out_cfg.fn_low[0]} == `FUNC_CLOCK)
        |=> (out_pins.level[0] == $past(low_speed_clock_out)))
        else $error("pin0 not carrying low speed clock");

    a_nch_drain: assert property (
        ({out_cfg.drv_high[2], out_cfg.drv_low[2]} == `DRV_NCH_OD)
        |=> (out_pins.oe[2] == ~out_pins.level[2]))
        else $error("n-channel pin drives high");

    a_write_answer: assert property (
        (aw_held && w_held && !bvalid) |=> (bvalid && !aw_held && !w_held))
        else $error("write response missing");

endmodule

// *** tb/pin_model.sv ***
module pin_model (
    input  wire logic                mclk,
    input  wire port_pkg::pull_ctl_t pull_ctl,
    input  wire logic [1:0]          drv_en,
    input  wire logic [1:0]          drv_val,
    output logic                     first_input_pin,
    output logic                     second_input_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       wander = 1'b0;
    logic [1:0] lvl;
    // an undriven, unpulled pin wanders so a stale value never reads back by luck
    always @(posedge mclk) begin
        wander <= ~wander;
    end
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            if (drv_en[i])
                lvl[i] = drv_val[i];
            else if (pull_ctl.up[i])
                lvl[i] = 1'b1;
            else if (pull_ctl.down[i])
                lvl[i] = 1'b0;
            else
                lvl[i] = wander ^ (i == 1);
        end
    end
    assign first_input_pin  = lvl[0];
    assign second_input_pin = lvl[1];
endmodule

// *** tb/tb.sv ***
`include "port_defs.svh"
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic                 mclk, rst_n, awvalid, wvalid, bready, arvalid, rready;
    logic                 awready, wready, bvalid, arready, rvalid;
    logic [`ADDR_W-1:0]   awaddr, araddr;
    logic [2:0]           awprot, arprot;
    logic [31:0]          wdata, rdata;
    logic [3:0]           wstrb;
    logic [1:0]           bresp, rresp, osc_mode, osc_pin_owned, drv_en, drv_val;
    logic                 first_input_pin, second_input_pin;
    logic                 low_speed_clock_out, high_speed_clock_out;
    logic                 timer_nine_output, timer_b_output;
    port_pkg::out_pins_t  out_pins;
    port_pkg::pull_ctl_t  pull_ctl;
    int                   miscompares = 0;
    int                   comparisons = 0;

    input_port1_output_port2 input_port1_output_port2_inst (.mclk, .rst_n, .awaddr, .awprot,
        .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
        .araddr, .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .first_input_pin, .second_input_pin, .osc_mode, .low_speed_clock_out,
        .high_speed_clock_out, .timer_nine_output, .timer_b_output, .out_pins, .pull_ctl,
        .osc_pin_owned);
    pin_model pin_model_inst (.mclk, .pull_ctl, .drv_en, .drv_val, .first_input_pin,
        .second_input_pin);

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic report_and_stop;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // callers enter just after a rising edge; an idle edge at the end keeps bready clean
    task automatic bus_write(input logic [15:0] idx, input logic [31:0] d, input logic [3:0] s,
                             input logic [1:0] er);
        int n = 0;
        awaddr <= {idx, 2'b00};
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (!bvalid && n < 50);
        bready <= 1'b0;
        chk("write done", 32'h1, {31'h0, bvalid});
        chk("bresp", {30'h0, er}, {30'h0, bresp});
        @(posedge mclk);
    endtask

    task automatic bus_read(input logic [15:0] idx, input logic [31:0] e, input logic [1:0] er,
                            input string what);
        int n = 0;
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
            if (arready)
                arvalid <= 1'b0;
        end while (!rvalid && n < 50);
        rready <= 1'b0;
        chk(what, e, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        @(posedge mclk);
    endtask

    task automatic t_reset_values;
        rst_n <= 1'b0;
        repeat (10) @(posedge mclk);
        chk("out_pins", 32'h0, {24'h0, out_pins});
        chk("pull_ctl", 32'h0, {28'h0, pull_ctl});
        chk("owned", 32'h0, {30'h0, osc_pin_owned});
        rst_n <= 1'b1;
        @(posedge mclk);
        bus_read(`IDX_PULL_LOW, 32'h0, `RESP_OKAY, "pull word");
        bus_read(`IDX_LATCH, 32'h0, `RESP_OKAY, "latch");
        bus_read(`IDX_DRIVE_LOW, 32'h0, `RESP_OKAY, "drive word");
        bus_read(`IDX_FUNC_LOW, 32'h0, `RESP_OKAY, "func low");
        bus_read(`IDX_FUNC_HIGH, 32'h0, `RESP_OKAY, "func high");
    endtask

    task automatic t_pull;
        logic [1:0] c;
        drv_en <= 2'b00;
        for (int i = 0; i < 4; i++) begin
            c = i[1:0];
            bus_write(`IDX_PULL_LOW, {22'h0, {2{c[1]}}, 6'h0, {2{c[0]}}}, 4'h3, `RESP_OKAY);
            repeat (2) @(posedge mclk);
            chk("pull up", {30'h0, {2{c == 2'b10}}}, {30'h0, pull_ctl.up});
            chk("pull down", {30'h0, {2{c == 2'b01}}}, {30'h0, pull_ctl.down});
            bus_read(`IDX_PULL_HIGH, {30'h0, {2{c[1]}}}, `RESP_OKAY, "pull high");
            if (c == 2'b01 || c == 2'b10)
                bus_read(`IDX_PIN_LEVEL, {30'h0, {2{c[1]}}}, `RESP_OKAY, "pulled");
        end
    endtask

    // pulls end high-impedance, as oscillator use needs
    task automatic t_osc;
        logic [31:0] e;
        bus_write(`IDX_PULL_LOW, 32'h0, 4'h3, `RESP_OKAY);
        drv_en <= 2'b11;
        for (int m = 0; m < 4; m++) begin
            for (int v = 0; v < 4; v++) begin
                osc_mode <= m[1:0];
                drv_val <= v[1:0];
                repeat (3) @(posedge mclk);
                e = (m == 0) ? 32'h0 : (m == 1) ? 32'(v & 2) : 32'(v);
                bus_read(`IDX_PIN_LEVEL, e, `RESP_OKAY, "pin level");
            end
            e = (m == 0) ? 32'h3 : (m == 1) ? 32'h1 : 32'h0;
            chk("owned", e, {30'h0, osc_pin_owned});
        end
        bus_write(`IDX_PIN_LEVEL, 32'h0, 4'hf, `RESP_OKAY);
        bus_read(`IDX_PIN_LEVEL, 32'h3, `RESP_OKAY, "level kept");
        osc_mode <= 2'b10;
    endtask

    task automatic t_out;
        logic [1:0] c;
        logic [3:0] oe;
        logic [31:0] d;
        bus_write(`IDX_LATCH, 32'hffff_ff65, 4'hf, `RESP_OKAY);
        bus_read(`IDX_LATCH, 32'h5, `RESP_OKAY, "latch");
        for (int i = 0; i < 4; i++) begin
            c = i[1:0];
            d = {20'h0, {4{c[1]}}, 4'h0, {4{c[0]}}};
            bus_write(`IDX_DRIVE_LOW, d, 4'h3, `RESP_OKAY);
            repeat (2) @(posedge mclk);
            oe = (c == 2'b00) ? 4'h0 : (c == 2'b01) ? 4'h5 : (c == 2'b10) ? 4'ha : 4'hf;
            chk("out_pins", {24'h0, 4'h5, oe}, {24'h0, out_pins});
            bus_read(`IDX_DRIVE_HIGH, {28'h0, {4{c[1]}}}, `RESP_OKAY, "drive high");
        end
    endtask

    task automatic t_func;
        bus_write(`IDX_FUNC_LOW, 32'h3, 4'h1, `RESP_OKAY);
        bus_write(`IDX_FUNC_HIGH, 32'hc, 4'h1, `RESP_OKAY);
        for (int v = 0; v < 16; v++) begin
            {timer_b_output, timer_nine_output,
             high_speed_clock_out, low_speed_clock_out} <= v[3:0];
            repeat (3) @(posedge mclk);
            chk("secondary", {24'h0, v[3:0], 4'hf}, {24'h0, out_pins});
        end
        // forbidden codes on every pin must fall back to the latch
        for (int k = 0; k < 2; k++) begin
            bus_write(`IDX_FUNC_LOW, k ? 32'hf : 32'hc, 4'h1, `RESP_OKAY);
            bus_write(`IDX_FUNC_HIGH, k ? 32'hf : 32'h3, 4'h1, `RESP_OKAY);
            repeat (2) @(posedge mclk);
            chk("forbidden", {24'h0, 4'h5, 4'hf}, {24'h0, out_pins});
        end
        // leave pulls non-zero so the closing reset has something to clear
        bus_write(`IDX_PULL_LOW, 32'h0000_0102, 4'h3, `RESP_OKAY);
        bus_write(16'hf209, 32'hff, 4'hf, `RESP_SLVERR);
        bus_read(16'hf211, 32'h0, `RESP_SLVERR, "unmapped");
    endtask

    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        {awaddr, araddr, wdata, wstrb, awprot, arprot} = '0;
        {drv_en, drv_val} = 4'h0;
        osc_mode = 2'b10;
        {timer_b_output, timer_nine_output, high_speed_clock_out, low_speed_clock_out} = 4'h0;
        t_reset_values;
        t_pull;
        t_osc;
        t_out;
        t_func;
        t_reset_values;
        report_and_stop;
    end

    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        report_and_stop;
    end
endmodule
